// File: core/gpmx_pkg.sv
// shared constants and types for the port E/F/G pin function block
package gpmx_pkg;
	localparam int NPIN = 26;
	localparam int E_BASE = 0;
	localparam int F_BASE = 9;
	localparam int G_BASE = 18;
	localparam int E_PINS = 9;
	localparam int F_PINS = 9;
	localparam int G_PINS = 8;
	localparam int E_PU_W = 8;
	localparam int E_FUNC_W = 18;
	localparam int F_FUNC_W = 22;
	localparam int G_FUNC_W = 16;
	// port F pins 5..8 carry 3-bit fields starting at bit 10
	localparam int F_WIDE_FIRST = 5;
	localparam int F_WIDE_LSB = 10;

	localparam logic [31:0] ADDR_E_FUNC = 32'h01D2_0028;
	localparam logic [31:0] ADDR_E_DATA = 32'h01D2_002C;
	localparam logic [31:0] ADDR_E_PUD = 32'h01D2_0030;
	localparam logic [31:0] ADDR_F_FUNC = 32'h01D2_0034;
	localparam logic [31:0] ADDR_F_DATA = 32'h01D2_0038;
	localparam logic [31:0] ADDR_F_PUD = 32'h01D2_003C;
	localparam logic [31:0] ADDR_G_FUNC = 32'h01D2_0040;
	localparam logic [31:0] ADDR_G_DATA = 32'h01D2_0044;
	localparam logic [31:0] ADDR_G_PUD = 32'h01D2_0048;

	localparam logic [E_FUNC_W-1:0] RST_E_FUNC = 18'h0_0000;
	localparam logic [F_FUNC_W-1:0] RST_F_FUNC = 22'h00_0000;
	localparam logic [G_FUNC_W-1:0] RST_G_FUNC = 16'h0000;
	localparam logic [NPIN-1:0] RST_PUD = 26'h000_0000;
	localparam logic [NPIN-1:0] RST_DATA = 26'h000_0000;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam logic [2:0] CODE_IN = 3'h0;
	localparam logic [2:0] CODE_OUT = 3'h1;
	localparam logic [2:0] CODE_ALT0 = 3'h2;
	localparam logic [2:0] CODE_ALT1 = 3'h3;
	localparam logic [2:0] CODE_ALT2 = 3'h4;

	typedef enum logic [5:0] {
		MD_IN = 6'h01,
		MD_OUT = 6'h02,
		MD_ALT0 = 6'h04,
		MD_ALT1 = 6'h08,
		MD_ALT2 = 6'h10,
		MD_NODRV = 6'h20
	} gpmx_mode_e;

	typedef enum logic [1:0] {
		WR_IDLE = 2'h1,
		WR_RESP = 2'h2
	} gpmx_wr_e;

	typedef enum logic [1:0] {
		RD_IDLE = 2'h1,
		RD_DATA = 2'h2
	} gpmx_rd_e;

	// peripheral drive request per alternate slot (0: code 10, 1: code 11, 2: code 100)
	typedef struct packed {
		logic [2:0] drv;
		logic [2:0] oe;
	} gpmx_alt_s;
endpackage : gpmx_pkg

// File: core/gpmx_sync.sv
// two-flop synchroniser for pad-side levels
module gpmx_sync #(
	parameter int W = 1
) (
	input wire logic CLK_I,
	input wire logic RESET_N_I,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			meta_reg <= '0;
			sync_o <= '0;
		end else begin
			meta_reg <= async_i;
			sync_o <= meta_reg;
		end
	end
endmodule : gpmx_sync

// File: core/gpmx_top.sv
// port E/F/G pin function multiplexer with AXI4-Lite register access
// Behaviour
// - port E pins 1-7: 00 in, 01 out, alternates
// - E4/E5 code 11 feeds timer clock input
// - E0: 10 drives PLL clock, 11 main clock
// - E8 field [17:16], 10 drives codec clock
// - output pin drives its data bit
// - input pin reads back sampled pad level
// - alternate pin data readback is undefined
// - pull-up bit 0 enables, 1 disables
// - E8 has no pull-up, eight bits only
// - F5-F8 3-bit fields, three alternates
// - F3/F4 bus and DMA handshake alternates
// - F2 wait, F1/F0 two-wire, 11 reserved
// - G pins: 10 alternate, 11 external interrupt
// - port F function and pull-up clear on reset
// - port G function and pull-up clear on reset
// - port E function and pull-up clear on reset
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
module gpmx_top #(
	parameter int AW = 32
) (
	input wire logic CLK_I,
	input wire logic RESET_N_I,
	input wire logic [AW-1:0] S_AXI_AWADDR_I,
	input wire logic S_AXI_AWVALID_I,
	output logic S_AXI_AWREADY_O,
	input wire logic [31:0] S_AXI_WDATA_I,
	input wire logic [3:0] S_AXI_WSTRB_I,
	input wire logic S_AXI_WVALID_I,
	output logic S_AXI_WREADY_O,
	output logic [1:0] S_AXI_BRESP_O,
	output logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	input wire logic [AW-1:0] S_AXI_ARADDR_I,
	input wire logic S_AXI_ARVALID_I,
	output logic S_AXI_ARREADY_O,
	output logic [31:0] S_AXI_RDATA_O,
	output logic [1:0] S_AXI_RRESP_O,
	output logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I,
	input wire logic [gpmx_pkg::NPIN-1:0] PAD_IN_I,
	output logic [gpmx_pkg::NPIN-1:0] PAD_OUT_O,
	output logic [gpmx_pkg::NPIN-1:0] PAD_OE_N_O,
	output logic [gpmx_pkg::NPIN-1:0] PULLUP_EN_O,
	input gpmx_pkg::gpmx_alt_s [gpmx_pkg::NPIN-1:0] ALT_I,
	output logic [gpmx_pkg::NPIN-1:0] ALT_IN_O,
	input wire logic PLL_CLK_I,
	input wire logic MAIN_CLK_I,
	input wire logic CODEC_CLK_I,
	output logic EXT_TIMER_CLK_O,
	output logic [gpmx_pkg::G_PINS-1:0] EXT_IRQ_O
);
	import gpmx_pkg::*;

	logic [E_FUNC_W-1:0] e_func_reg;
	logic [F_FUNC_W-1:0] f_func_reg;
	logic [G_FUNC_W-1:0] g_func_reg;
	logic [NPIN-1:0] data_reg;
	logic [NPIN-1:0] pud_reg;
	logic [NPIN-1:0] pad_sync;
	logic [2:0] clk_sync;
	gpmx_mode_e mode [NPIN];
	logic [2:0] code [NPIN];

	gpmx_wr_e wr_state_reg;
	gpmx_rd_e rd_state_reg;
	logic aw_have_reg;
	logic w_have_reg;
	logic [AW-1:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic aw_take;
	logic w_take;
	logic wr_go;
	logic [AW-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [31:0] rd_word;
	logic rd_hit;
	logic wr_hit;

	// pads and foreign clocks are resynchronised before use
	gpmx_sync #(.W(NPIN)) u_pad_sync (
		.CLK_I(CLK_I),
		.RESET_N_I(RESET_N_I),
		.async_i(PAD_IN_I),
		.sync_o(pad_sync)
	);

	gpmx_sync #(.W(3)) u_clk_sync (
		.CLK_I(CLK_I),
		.RESET_N_I(RESET_N_I),
		.async_i({CODEC_CLK_I, MAIN_CLK_I, PLL_CLK_I}),
		.sync_o(clk_sync)
	);

	// byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return res;
	endfunction : merge

	// field code of pin p, 2-bit fields widened with a zero
	function automatic logic [2:0] pin_code(input int p, input logic [E_FUNC_W-1:0] ef,
			input logic [F_FUNC_W-1:0] ff, input logic [G_FUNC_W-1:0] gf);
		logic [2:0] c;
		c = 3'h0;
		if (p < F_BASE) begin
			c = {1'b0, ef[2*p +: 2]};
		end else if (p < F_BASE + F_WIDE_FIRST) begin
			c = {1'b0, ff[2*(p-F_BASE) +: 2]};
		end else if (p < G_BASE) begin
			c = ff[F_WIDE_LSB + 3*(p-F_BASE-F_WIDE_FIRST) +: 3];
		end else begin
			c = {1'b0, gf[2*(p-G_BASE) +: 2]};
		end
		return c;
	endfunction : pin_code

	// reserved codes and input-only alternates never drive the pad
	function automatic gpmx_mode_e pin_mode(input int p, input logic [2:0] c);
		gpmx_mode_e m;
		m = MD_NODRV;
		case (c)
			CODE_IN: m = MD_IN;
			CODE_OUT: m = MD_OUT;
			CODE_ALT0: m = MD_ALT0;
			CODE_ALT1: m = MD_ALT1;
			CODE_ALT2: m = MD_ALT2;
			default: m = MD_NODRV;
		endcase
		if (c == CODE_ALT2 && (p < F_BASE + F_WIDE_FIRST || p >= G_BASE)) begin
			m = MD_NODRV;
		end
		if (c == CODE_ALT1) begin
			if (p == 1 || p == 2 || p == 3 || p == 8) begin
				m = MD_NODRV;
			end else if (p == 4 || p == 5 || p >= G_BASE) begin
				m = MD_NODRV;
			end else if (p >= F_BASE && p <= F_BASE + 2) begin
				m = MD_NODRV;
			end
		end
		if (p == E_PINS - 1 && c == CODE_IN) begin
			m = MD_NODRV;
		end
		return m;
	endfunction : pin_mode

	always_comb begin
		for (int p = 0; p < NPIN; p++) begin
			code[p] = pin_code(p, e_func_reg, f_func_reg, g_func_reg);
			mode[p] = pin_mode(p, code[p]);
		end
	end

	// pad drive, output enable is active low
	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			PAD_OUT_O <= '0;
			PAD_OE_N_O <= '1;
		end else begin
			for (int p = 0; p < NPIN; p++) begin
				PAD_OUT_O[p] <= 1'b0;
				PAD_OE_N_O[p] <= 1'b1;
				case (mode[p])
					MD_OUT: begin
						PAD_OUT_O[p] <= data_reg[p];
						PAD_OE_N_O[p] <= 1'b0;
					end
					MD_ALT0: begin
						PAD_OUT_O[p] <= ALT_I[p].drv[0];
						PAD_OE_N_O[p] <= ~ALT_I[p].oe[0];
					end
					MD_ALT1: begin
						PAD_OUT_O[p] <= ALT_I[p].drv[1];
						PAD_OE_N_O[p] <= ~ALT_I[p].oe[1];
					end
					MD_ALT2: begin
						PAD_OUT_O[p] <= ALT_I[p].drv[2];
						PAD_OE_N_O[p] <= ~ALT_I[p].oe[2];
					end
					default: begin
						PAD_OUT_O[p] <= 1'b0;
						PAD_OE_N_O[p] <= 1'b1;
					end
				endcase
			end
			if (mode[0] == MD_ALT0) begin
				PAD_OUT_O[0] <= clk_sync[0];
				PAD_OE_N_O[0] <= 1'b0;
			end else if (mode[0] == MD_ALT1) begin
				PAD_OUT_O[0] <= clk_sync[1];
				PAD_OE_N_O[0] <= 1'b0;
			end
			if (mode[E_PINS-1] == MD_ALT0) begin
				PAD_OUT_O[E_PINS-1] <= clk_sync[2];
				PAD_OE_N_O[E_PINS-1] <= 1'b0;
			end
		end
	end

	// peripheral-facing inputs idle high when the pin is not handed over, the timer clock idles low
	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			ALT_IN_O <= '1;
			EXT_TIMER_CLK_O <= 1'b0;
			EXT_IRQ_O <= '1;
		end else begin
			for (int p = 0; p < NPIN; p++) begin
				ALT_IN_O[p] <= (code[p] >= CODE_ALT0) ? pad_sync[p] : 1'b1;
			end
			if (code[4] == CODE_ALT1) begin
				EXT_TIMER_CLK_O <= pad_sync[4];
			end else if (code[5] == CODE_ALT1) begin
				EXT_TIMER_CLK_O <= pad_sync[5];
			end else begin
				EXT_TIMER_CLK_O <= 1'b0;
			end
			for (int g = 0; g < G_PINS; g++) begin
				EXT_IRQ_O[g] <= (code[G_BASE+g] == CODE_ALT1) ? pad_sync[G_BASE+g] : 1'b1;
			end
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			PULLUP_EN_O <= '0;
		end else begin
			PULLUP_EN_O <= ~pud_reg;
			PULLUP_EN_O[E_PINS-1] <= 1'b0;
		end
	end

	// write channel: address and data accepted in either order
	assign aw_take = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
	assign w_take = S_AXI_WVALID_I && S_AXI_WREADY_O;
	assign wr_addr = aw_have_reg ? aw_addr_reg : S_AXI_AWADDR_I;
	assign wr_data = w_have_reg ? w_data_reg : S_AXI_WDATA_I;
	assign wr_strb = w_have_reg ? w_strb_reg : S_AXI_WSTRB_I;
	assign wr_go = (wr_state_reg == WR_IDLE) && (aw_have_reg || aw_take)
		&& (w_have_reg || w_take);

	always_comb begin
		wr_hit = 1'b1;
		if (wr_addr == ADDR_E_FUNC) begin
			wr_hit = 1'b1;
		end else if (wr_addr == ADDR_E_DATA || wr_addr == ADDR_E_PUD) begin
			wr_hit = 1'b1;
		end else if (wr_addr == ADDR_F_FUNC || wr_addr == ADDR_F_DATA) begin
			wr_hit = 1'b1;
		end else if (wr_addr == ADDR_F_PUD || wr_addr == ADDR_G_FUNC) begin
			wr_hit = 1'b1;
		end else if (wr_addr == ADDR_G_DATA || wr_addr == ADDR_G_PUD) begin
			wr_hit = 1'b1;
		end else begin
			wr_hit = 1'b0;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			wr_state_reg <= WR_IDLE;
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_data_reg <= '0;
			w_strb_reg <= '0;
			S_AXI_AWREADY_O <= 1'b1;
			S_AXI_WREADY_O <= 1'b1;
			S_AXI_BVALID_O <= 1'b0;
			S_AXI_BRESP_O <= RESP_OKAY;
		end else begin
			case (wr_state_reg)
				WR_IDLE: begin
					if (wr_go) begin
						wr_state_reg <= WR_RESP;
						aw_have_reg <= 1'b0;
						w_have_reg <= 1'b0;
						S_AXI_AWREADY_O <= 1'b0;
						S_AXI_WREADY_O <= 1'b0;
						S_AXI_BVALID_O <= 1'b1;
						S_AXI_BRESP_O <= wr_hit ? RESP_OKAY : RESP_SLVERR;
					end else begin
						if (aw_take) begin
							aw_have_reg <= 1'b1;
							aw_addr_reg <= S_AXI_AWADDR_I;
							S_AXI_AWREADY_O <= 1'b0;
						end
						if (w_take) begin
							w_have_reg <= 1'b1;
							w_data_reg <= S_AXI_WDATA_I;
							w_strb_reg <= S_AXI_WSTRB_I;
							S_AXI_WREADY_O <= 1'b0;
						end
					end
				end
				WR_RESP: begin
					if (S_AXI_BREADY_I) begin
						wr_state_reg <= WR_IDLE;
						S_AXI_BVALID_O <= 1'b0;
						S_AXI_AWREADY_O <= 1'b1;
						S_AXI_WREADY_O <= 1'b1;
					end
				end
				default: begin
					wr_state_reg <= WR_IDLE;
				end
			endcase
		end
	end

	// register stores update at the edge that completes the write
	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			e_func_reg <= RST_E_FUNC;
			f_func_reg <= RST_F_FUNC;
			g_func_reg <= RST_G_FUNC;
			pud_reg <= RST_PUD;
			data_reg <= RST_DATA;
		end else if (wr_go) begin
			if (wr_addr == ADDR_E_FUNC) begin
				e_func_reg <= E_FUNC_W'(merge(32'(e_func_reg), wr_data, wr_strb));
			end else if (wr_addr == ADDR_F_FUNC) begin
				f_func_reg <= F_FUNC_W'(merge(32'(f_func_reg), wr_data, wr_strb));
			end else if (wr_addr == ADDR_G_FUNC) begin
				g_func_reg <= G_FUNC_W'(merge(32'(g_func_reg), wr_data, wr_strb));
			end else if (wr_addr == ADDR_E_DATA) begin
				data_reg[E_BASE +: E_PINS] <= E_PINS'(merge(
					32'(data_reg[E_BASE +: E_PINS]), wr_data, wr_strb));
			end else if (wr_addr == ADDR_F_DATA) begin
				data_reg[F_BASE +: F_PINS] <= F_PINS'(merge(
					32'(data_reg[F_BASE +: F_PINS]), wr_data, wr_strb));
			end else if (wr_addr == ADDR_G_DATA) begin
				data_reg[G_BASE +: G_PINS] <= G_PINS'(merge(
					32'(data_reg[G_BASE +: G_PINS]), wr_data, wr_strb));
			end else if (wr_addr == ADDR_E_PUD) begin
				pud_reg[E_BASE +: E_PU_W] <= E_PU_W'(merge(
					32'(pud_reg[E_BASE +: E_PU_W]), wr_data, wr_strb));
			end else if (wr_addr == ADDR_F_PUD) begin
				pud_reg[F_BASE +: F_PINS] <= F_PINS'(merge(
					32'(pud_reg[F_BASE +: F_PINS]), wr_data, wr_strb));
			end else if (wr_addr == ADDR_G_PUD) begin
				pud_reg[G_BASE +: G_PINS] <= G_PINS'(merge(
					32'(pud_reg[G_BASE +: G_PINS]), wr_data, wr_strb));
			end
		end
	end

	// readback: inputs and alternates show the pad, outputs show the latch
	function automatic logic [31:0] port_read(input int base, input int n,
			input logic [NPIN-1:0] dat, input logic [NPIN-1:0] pad);
		logic [31:0] v;
		v = 32'h0000_0000;
		for (int i = 0; i < n; i++) begin
			v[i] = (mode[base+i] == MD_OUT) ? dat[base+i] : pad[base+i];
		end
		return v;
	endfunction : port_read

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit = 1'b1;
		if (S_AXI_ARADDR_I == ADDR_E_FUNC) begin
			rd_word = 32'(e_func_reg);
		end else if (S_AXI_ARADDR_I == ADDR_F_FUNC) begin
			rd_word = 32'(f_func_reg);
		end else if (S_AXI_ARADDR_I == ADDR_G_FUNC) begin
			rd_word = 32'(g_func_reg);
		end else if (S_AXI_ARADDR_I == ADDR_E_DATA) begin
			rd_word = port_read(E_BASE, E_PINS, data_reg, pad_sync);
		end else if (S_AXI_ARADDR_I == ADDR_F_DATA) begin
			rd_word = port_read(F_BASE, F_PINS, data_reg, pad_sync);
		end else if (S_AXI_ARADDR_I == ADDR_G_DATA) begin
			rd_word = port_read(G_BASE, G_PINS, data_reg, pad_sync);
		end else if (S_AXI_ARADDR_I == ADDR_E_PUD) begin
			rd_word = 32'(pud_reg[E_BASE +: E_PU_W]);
		end else if (S_AXI_ARADDR_I == ADDR_F_PUD) begin
			rd_word = 32'(pud_reg[F_BASE +: F_PINS]);
		end else if (S_AXI_ARADDR_I == ADDR_G_PUD) begin
			rd_word = 32'(pud_reg[G_BASE +: G_PINS]);
		end else begin
			rd_hit = 1'b0;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			rd_state_reg <= RD_IDLE;
			S_AXI_ARREADY_O <= 1'b1;
			S_AXI_RVALID_O <= 1'b0;
			S_AXI_RDATA_O <= 32'h0000_0000;
			S_AXI_RRESP_O <= RESP_OKAY;
		end else begin
			case (rd_state_reg)
				RD_IDLE: begin
					if (S_AXI_ARVALID_I) begin
						rd_state_reg <= RD_DATA;
						S_AXI_ARREADY_O <= 1'b0;
						S_AXI_RVALID_O <= 1'b1;
						S_AXI_RDATA_O <= rd_word;
						S_AXI_RRESP_O <= rd_hit ? RESP_OKAY : RESP_SLVERR;
					end
				end
				RD_DATA: begin
					if (S_AXI_RREADY_I) begin
						rd_state_reg <= RD_IDLE;
						S_AXI_RVALID_O <= 1'b0;
						S_AXI_ARREADY_O <= 1'b1;
					end
				end
				default: begin
					rd_state_reg <= RD_IDLE;
				end
			endcase
		end
	end
endmodule : gpmx_top

// File: test/gpmx_monitor.sv
// concurrent checks on the port E/F/G pin function block ports
module gpmx_monitor import gpmx_pkg::*; (
	input logic CLK_I,
	input logic RESET_N_I,
	input logic S_AXI_AWVALID_I,
	input logic S_AXI_AWREADY_O,
	input logic S_AXI_WVALID_I,
	input logic S_AXI_WREADY_O,
	input logic S_AXI_BVALID_O,
	input logic S_AXI_BREADY_I,
	input logic S_AXI_ARVALID_I,
	input logic S_AXI_ARREADY_O,
	input logic S_AXI_RVALID_O,
	input logic S_AXI_RREADY_I,
	input logic [NPIN-1:0] PAD_IN_I,
	input logic [NPIN-1:0] PAD_OE_N_O,
	input logic [NPIN-1:0] PULLUP_EN_O,
	input logic EXT_TIMER_CLK_O,
	input logic [G_PINS-1:0] EXT_IRQ_O
);
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RESET_N_I);
	sequence s_wr_take;
		S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
	endsequence
	sequence s_rd_take;
		S_AXI_ARVALID_I && S_AXI_ARREADY_O;
	endsequence
	AST_WR_RESP: assert property (s_wr_take |=> S_AXI_BVALID_O && !S_AXI_AWREADY_O)
		else $error("write response missing");
	AST_B_DONE: assert property (S_AXI_BVALID_O && S_AXI_BREADY_I |=> !S_AXI_BVALID_O && S_AXI_AWREADY_O)
		else $error("write response not closed");
	AST_RD_RESP: assert property (s_rd_take |=> S_AXI_RVALID_O && !S_AXI_ARREADY_O)
		else $error("read data missing");
	AST_R_DONE: assert property (S_AXI_RVALID_O && S_AXI_RREADY_I |=> !S_AXI_RVALID_O && S_AXI_ARREADY_O)
		else $error("read not closed");
	AST_E8_NO_PULL: assert property (!PULLUP_EN_O[8])
		else $error("pin E8 pull-up on");
	AST_RESET_STATE: assert property ($rose(RESET_N_I) |-> &PAD_OE_N_O && &EXT_IRQ_O)
		else $error("pins not inputs after reset");
	AST_IRQ_SRC: assert property ((~EXT_IRQ_O & $past(PAD_IN_I[25:18], 3)) == 8'h00)
		else $error("interrupt line not from its pad");
	AST_TMR_SRC: assert property (EXT_TIMER_CLK_O |-> $past(PAD_IN_I[4], 3) || $past(PAD_IN_I[5], 3))
		else $error("timer clock not from pad");
	AST_OE_AFTER_WR: assert property ($changed(PAD_OE_N_O) |-> $past(S_AXI_BVALID_O) && !$past(S_AXI_BVALID_O, 2))
		else $error("pad enable moved without a write");
endmodule : gpmx_monitor

// File: test/gpmx_pad_model.sv
// package pins: design drive, outside drive, pull-up or a floating level
module gpmx_pad_model import gpmx_pkg::*; (
	input logic clk_i,
	input logic [NPIN-1:0] pad_out_i,
	input logic [NPIN-1:0] pad_oe_n_i,
	input logic [NPIN-1:0] pullup_en_i,
	input logic [NPIN-1:0] ext_val_i,
	input logic [NPIN-1:0] ext_en_i,
	output logic [NPIN-1:0] pad_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [NPIN-1:0] flip_reg = '0;
	// a floating pin without pull-up keeps no level
	always_ff @(posedge clk_i) flip_reg <= ~flip_reg;
	always_comb begin
		for (int i = 0; i < NPIN; i++) begin
			pad_o[i] = !pad_oe_n_i[i] ? pad_out_i[i] :
				ext_en_i[i] ? ext_val_i[i] : pullup_en_i[i] ? 1'b1 : flip_reg[i];
		end
	end
endmodule : gpmx_pad_model

// File: test/tb_gpio_ports_e_f_g_pin_mux.sv
// self-checking bench for the port E/F/G pin function block
module tb_gpio_ports_e_f_g_pin_mux import gpmx_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [31:0] aw_addr = '0, w_data = '0, ar_addr = '0, rd_data, r_data;
	logic aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0, ar_valid = 1'b0, r_ready = 1'b0;
	logic aw_rdy, w_rdy, b_valid, ar_rdy, r_valid, tmr_clk;
	logic [1:0] b_resp, r_resp, wr_resp, rd_resp;
	logic [3:0] w_strb = 4'hF;
	logic [2:0] slow_cnt = 3'h0;
	logic [7:0] irq;
	logic [NPIN-1:0] pad_lvl, pad_out, pad_oe_n, pull_en, alt_in;
	logic [NPIN-1:0] ext_val = '0, ext_en = '1;
	gpmx_alt_s [NPIN-1:0] alt_drv = '0;
	int mismatches = 0;
	int samples_checked = 0;
	logic [31:0] regs [9] = '{ADDR_E_FUNC, ADDR_E_DATA, ADDR_E_PUD, ADDR_F_FUNC, ADDR_F_DATA,
		ADDR_F_PUD, ADDR_G_FUNC, ADDR_G_DATA, ADDR_G_PUD};
	// address, write value, read-back value
	logic [31:0] rows [6][3] = '{'{ADDR_E_FUNC, 32'hFFFFFFFF, 32'h0003FFFF},
		'{ADDR_F_FUNC, 32'hFFFFFFFF, 32'h003FFFFF}, '{ADDR_G_FUNC, 32'hFFFFFFFF, 32'h0000FFFF},
		'{ADDR_E_PUD, 32'hFFFFFFFF, 32'h000000FF}, '{ADDR_F_PUD, 32'hFFFFFFFF, 32'h000001FF},
		'{ADDR_G_PUD, 32'hFFFFFFFF, 32'h000000FF}};

	gpmx_top DUT (.CLK_I(clk), .RESET_N_I(rst_n),
		.S_AXI_AWADDR_I(aw_addr), .S_AXI_AWVALID_I(aw_valid), .S_AXI_AWREADY_O(aw_rdy),
		.S_AXI_WDATA_I(w_data), .S_AXI_WSTRB_I(w_strb), .S_AXI_WVALID_I(w_valid),
		.S_AXI_WREADY_O(w_rdy), .S_AXI_BRESP_O(b_resp), .S_AXI_BVALID_O(b_valid),
		.S_AXI_BREADY_I(b_ready), .S_AXI_ARADDR_I(ar_addr), .S_AXI_ARVALID_I(ar_valid),
		.S_AXI_ARREADY_O(ar_rdy), .S_AXI_RDATA_O(r_data), .S_AXI_RRESP_O(r_resp),
		.S_AXI_RVALID_O(r_valid), .S_AXI_RREADY_I(r_ready), .PAD_IN_I(pad_lvl),
		.PAD_OUT_O(pad_out), .PAD_OE_N_O(pad_oe_n), .PULLUP_EN_O(pull_en), .ALT_I(alt_drv),
		.ALT_IN_O(alt_in), .PLL_CLK_I(slow_cnt[0]), .MAIN_CLK_I(slow_cnt[1]),
		.CODEC_CLK_I(slow_cnt[2]), .EXT_TIMER_CLK_O(tmr_clk), .EXT_IRQ_O(irq));

	gpmx_pad_model PADS (.clk_i(clk), .pad_out_i(pad_out), .pad_oe_n_i(pad_oe_n),
		.pullup_en_i(pull_en), .ext_val_i(ext_val), .ext_en_i(ext_en), .pad_o(pad_lvl));

	initial forever #2.5 clk = ~clk;
	always @(posedge clk) slow_cnt <= slow_cnt + 3'h1;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk);
		aw_addr <= a;
		w_data <= d;
		w_strb <= s;
		aw_valid <= 1'b1;
		w_valid <= 1'b1;
		b_ready <= 1'b1;
		do begin
			@(posedge clk);
			if (aw_rdy) aw_valid <= 1'b0;
			if (w_rdy) w_valid <= 1'b0;
		end while (!b_valid);
		wr_resp = b_resp;
		b_ready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [31:0] a);
		@(posedge clk);
		ar_addr <= a;
		ar_valid <= 1'b1;
		r_ready <= 1'b1;
		do begin
			@(posedge clk);
			if (ar_rdy) ar_valid <= 1'b0;
		end while (!r_valid);
		rd_data = r_data;
		rd_resp = r_resp;
		r_ready <= 1'b0;
	endtask : rd

	task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
		rd(a);
		chk(rd_data, exp);
	endtask : rchk

	task automatic do_reset;
		rst_n <= 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
	endtask : do_reset

	task automatic reset_chk;
		chk(32'(pull_en), 32'h03FFFEFF);
		chk(32'(pad_oe_n), 32'h03FFFFFF);
		foreach (regs[i]) if (i % 3 != 1) rchk(regs[i], 32'h0);
		$display("reset state test done");
	endtask : reset_chk

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test

	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		stop_test;
	end

	initial begin
		do_reset;
		reset_chk;
		foreach (rows[i]) begin
			wr(rows[i][0], rows[i][1], 4'hF);
			rchk(rows[i][0], rows[i][2]);
		end
		chk(32'(pull_en), 32'h0);
		wr(ADDR_G_PUD, 32'h0, 4'h0);
		rchk(ADDR_G_PUD, 32'hFF);
		$display("register rows test done");
		wr(ADDR_E_FUNC, 32'h15555, 4'hF);
		wr(ADDR_F_FUNC, 32'h92555, 4'hF);
		wr(ADDR_G_FUNC, 32'h5555, 4'hF);
		wr(ADDR_E_DATA, 32'h1A5, 4'hF);
		wr(ADDR_F_DATA, 32'h0C3, 4'hF);
		wr(ADDR_G_DATA, 32'h5A, 4'hF);
		rchk(ADDR_F_DATA, 32'h0C3);
		chk(32'(pad_oe_n), 32'h0);
		chk(32'(pad_out), {6'h0, 8'h5A, 9'h0C3, 9'h1A5});
		$display("output mode test done");
		ext_val <= {8'hB4, 9'h12D, 9'h0E7};
		for (int i = 0; i < 3; i++) wr(regs[3 * i], 32'h0, 4'hF);
		rchk(ADDR_E_DATA, 32'h0E7);
		rchk(ADDR_F_DATA, 32'h12D);
		rchk(ADDR_G_DATA, 32'hB4);
		wr(ADDR_F_PUD, 32'h0, 4'hF);
		ext_en <= '0;
		// the pulled-up level needs two edges to cross the pad synchroniser
		repeat (2) @(posedge clk);
		rchk(ADDR_F_DATA, 32'h1FF);
		ext_en <= '1;
		$display("input mode test done");
		ext_val <= {8'h5C, 9'h0, 9'h010};
		wr(ADDR_G_FUNC, 32'hFFFF, 4'hF);
		wr(ADDR_E_FUNC, 32'h20302, 4'hF);
		repeat (4) @(posedge clk);
		chk(32'(irq), 32'h5C);
		chk(32'(tmr_clk), 32'h1);
		chk(32'(pad_oe_n[8:0]), 32'h0FE);
		alt_drv <= {NPIN{6'h17}};
		wr(ADDR_F_FUNC, 32'h1B6CC3, 4'hF);
		repeat (2) @(posedge clk);
		chk(32'(pad_oe_n[17:9]), 32'h017);
		chk(32'({pad_out[17:14], pad_out[12]}), 32'h1F);
		wr(ADDR_F_FUNC, 32'h1000, 4'hF);
		repeat (2) @(posedge clk);
		chk(32'({pad_oe_n[14], pad_out[14]}), 32'h0);
		$display("alternate function test done");
		wr(ADDR_G_PUD + 32'h4, 32'hFF, 4'hF);
		chk(32'(wr_resp), 32'(RESP_SLVERR));
		rd(ADDR_G_PUD + 32'h4);
		chk(rd_data, 32'h0);
		chk(32'(rd_resp), 32'(RESP_SLVERR));
		$display("unmapped access test done");
		do_reset;
		reset_chk;
		stop_test;
	end
endmodule : tb_gpio_ports_e_f_g_pin_mux

bind gpmx_top gpmx_monitor MON (.CLK_I, .RESET_N_I, .S_AXI_AWVALID_I, .S_AXI_AWREADY_O,
	.S_AXI_WVALID_I, .S_AXI_WREADY_O, .S_AXI_BVALID_O, .S_AXI_BREADY_I, .S_AXI_ARVALID_I,
	.S_AXI_ARREADY_O, .S_AXI_RVALID_O, .S_AXI_RREADY_I, .PAD_IN_I, .PAD_OE_N_O,
	.PULLUP_EN_O, .EXT_TIMER_CLK_O, .EXT_IRQ_O);
